// ---- src/ssp_pkg.sv ----
package ssp_pkg;
	// ************************************************************
	// Register byte addresses.
	// ************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TXDATA = 8'h08;
	localparam logic [7:0] ADDR_RXDATA = 8'h0C;
	localparam logic [7:0] ADDR_BAUD = 8'h10;
	localparam logic [7:0] ADDR_IRQ = 8'h14;

	// ************************************************************
	// Control register field positions.
	// ************************************************************
	localparam int CTRL_PORT_EN = 0;
	localparam int CTRL_SYNC = 1;
	localparam int CTRL_MASTER = 2;
	localparam int CTRL_SINGLE_RX = 3;
	localparam int CTRL_CONT_RX = 4;
	localparam int CTRL_TX_EN = 5;
	localparam int CTRL_TX_NINE = 6;
	localparam int CTRL_TX_NINTH = 7;
	localparam int CTRL_RX_NINE = 8;
	localparam int CTRL_POLARITY = 9;

	// ************************************************************
	// Status and interrupt enable field positions.
	// ************************************************************
	localparam int STAT_RX_COMPLETE = 0;
	localparam int STAT_TX_EMPTY = 1;
	localparam int STAT_OVERRUN = 2;
	localparam int STAT_RX_NINTH = 3;
	localparam int STAT_SHIFT_EMPTY = 4;
	localparam int IRQ_RX_EN = 0;
	localparam int IRQ_TX_EN = 1;
	localparam int IRQ_PERIPH_EN = 2;
	localparam int IRQ_GLOBAL_EN = 3;

	// ************************************************************
	// Reset values and character lengths.
	// ************************************************************
	localparam logic [15:0] BAUD_RESET = 16'h0003;
	localparam logic [3:0] LAST_BIT_NARROW = 4'h7;
	localparam logic [3:0] LAST_BIT_WIDE = 4'h8;
	localparam logic [3:0] BITS_NARROW = 4'h8;
	localparam logic [3:0] BITS_WIDE = 4'h9;
	localparam int CHAR_WIDTH = 9;
	localparam int RX_FIFO_DEPTH = 2;
endpackage

// ---- src/ssp_sync2.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssp_sync2 (
	input wire logic hclk, // System clock.
	input wire logic hresetn, // Asynchronous reset, active low.
	input wire logic async_in, // Level from outside the clock domain.
	output logic sync_out // Level after two flip-flops.
);
	logic stage1;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage1 <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule
`default_nettype wire

// ---- src/ssp_rx_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssp_rx_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	input wire logic hclk, // System clock.
	input wire logic hresetn, // Asynchronous reset, active low.
	input wire logic flush, // Empties the queue.
	input wire logic push, // Stores push_data at the tail.
	input wire logic [WIDTH-1:0] push_data, // Character to store.
	input wire logic pop, // Drops the oldest entry.
	output logic [WIDTH-1:0] head_data, // Oldest entry, straight from a register.
	output logic empty, // No entry stored.
	output logic full // Every entry used.
);
	// Entry 0 is always the oldest, so the head comes straight from a register.
	logic [WIDTH-1:0] entry [DEPTH];
	logic [DEPTH:0] fill;
	logic [DEPTH:0] next_fill;
	logic do_pop;

	assign do_pop = pop && fill[0];
	assign head_data = entry[0];
	assign empty = fill[0] == 1'b0;
	assign full = fill[DEPTH-1];

	always_comb begin
		next_fill = fill;
		if (do_pop) begin
			next_fill = {1'b0, fill[DEPTH:1]};
		end
		if (push && !full) begin
			next_fill = {next_fill[DEPTH-1:0], 1'b1};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fill <= '0;
		end else if (flush) begin
			fill <= '0;
		end else begin
			fill <= next_fill;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				entry[i] <= '0;
			end
		end else begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				if (do_pop) begin
					entry[i] <= entry[i+1];
				end
			end
			// The tail write comes last so that it wins over the shift.
			for (int i = 0; i < DEPTH; i++) begin
				if (push && !full && next_fill[i] && !next_fill[i+1]) begin
					entry[i] <= push_data;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- src/ssp_top.sv ----
// Contract
// - Master receiver releases the data pin driver.
// - Reception starts when single or continuous receive is set.
// - Single receive clocks one character, then hardware clears it.
// - Continuous receive clocks nonstop; clearing aborts at once, partial character dropped.
// - Both set: single clears after first character, continuous keeps going.
// - Data sampled on the trailing clock edge into the shift register.
// - Full character moves to two-entry queue; low byte readable; flag set.
// - Receive flag stays set while any unread character remains.
// - Slave releases clock driver, one bit per external clock cycle.
// - Third character with two unread sets the overrun flag.
// - On overrun stored characters stay; nothing more accepted until cleared.
// - Single-mode overrun clears on data read; continuous needs enable drop.
// - Nine-bit mode shifts nine bits; top bit shown in status.
// - Slave selected by sync, not master, port on; enables choose direction.
// - Second queued word waits; transmit flag sets when it moves across.
// - Transmit flag with enables raises wake; vector also needs global enable.
// - Slave receives on continuous receive only; single receive ignored.
// - Slave accepts external character, buffers it, wakes if receive enabled.
// - Master drives one clock per data bit and no extra cycles.
// - Polarity set idles clock high; clear idles clock low.
// - Written character waits while shift register busy, else moves at once.
`timescale 1ns/1ps
`default_nettype none
module ssp_top (
	input wire logic hclk, // System clock, 125 MHz.
	input wire logic hresetn, // Asynchronous reset, active low.
	input wire logic hsel, // Slave select.
	input wire logic [7:0] haddr, // Byte address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write when high.
	input wire logic [2:0] hsize, // Transfer size, word only.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Bus ready.
	output logic [31:0] hrdata, // Read data.
	output logic hreadyout, // Low in reset, then always ready.
	output logic hresp, // Always OKAY.
	input wire logic ck_in, // Shift clock pin level.
	output logic ck_out, // Shift clock pin drive value.
	output logic ck_oe, // Shift clock pin driver enable.
	input wire logic dt_in, // Data pin level.
	output logic dt_out, // Data pin drive value.
	output logic dt_oe, // Data pin driver enable.
	output logic wake_req, // Wake request to the core.
	output logic vector_req // Wake with branch to the service routine.
);
	typedef enum logic [1:0] {CK_IDLE, CK_LEAD_HALF, CK_TRAIL_HALF} ssp_mck_type;

	// ************************************************************
	// Control and configuration registers.
	// ************************************************************
	logic port_enable, sync_mode, clock_source_master, single_rx_enable;
	logic continuous_rx_enable, tx_enable, tx_nine_bit_select, tx_ninth_bit;
	logic rx_nine_bit_select, clock_polarity_select;
	logic rx_irq_enable, tx_irq_enable, peripheral_irq_enable, global_irq_enable;
	logic [15:0] baud_divisor;
	logic overrun_error_flag, ovr_from_single;
	logic dp_write;
	logic [7:0] dp_addr;
	logic addr_phase, rd_pop;
	logic [8:0] tx_holding_register, tx_shift_register, rx_shift_register;
	logic hold_full, tx_shift_full;
	logic [3:0] tx_left, rx_cnt;
	ssp_mck_type mck_state;
	logic [15:0] half_cnt;
	logic mst_lead, mst_trail;
	logic ck_sync, dt_sync, ck_prev;
	logic lead_ev, trail_ev;
	logic [8:0] fifo_head;
	logic fifo_empty, fifo_full;

	// Derived modes.
	logic port_on, master_on, slave_on, single_eff, rx_mode, tx_mode, port_rst;
	logic rx_done, rx_push, rx_ovr_set, tx_shift_load, mck_run, tick;
	logic [8:0] rx_shift_next, rx_char;
	logic ck_norm, ck_prev_norm;
	logic rx_complete_flag, tx_buffer_empty_flag, rx_ninth_bit;

	assign port_on = port_enable && sync_mode;
	assign port_rst = !port_on;
	assign master_on = port_on && clock_source_master;
	assign slave_on = port_on && !clock_source_master;
	assign single_eff = single_rx_enable && clock_source_master;
	assign rx_mode = port_on && (single_eff || continuous_rx_enable);
	assign tx_mode = port_on && !(single_eff || continuous_rx_enable) && tx_enable;
	assign rx_complete_flag = !fifo_empty;
	assign tx_buffer_empty_flag = !hold_full;
	assign rx_ninth_bit = fifo_head[8];

	// ************************************************************
	// AHB-Lite slave: zero wait states, registered read data.
	// ************************************************************
	assign addr_phase = hsel && htrans[1] && hready;
	assign rd_pop = addr_phase && !hwrite && haddr == ssp_pkg::ADDR_RXDATA;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			dp_write <= addr_phase && hwrite;
			dp_addr <= haddr;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Reads sample state at the address phase, so a write in the data phase
	// of the previous transfer is not yet visible.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			unique case (haddr)
				ssp_pkg::ADDR_CTRL: hrdata <= {22'h000000, clock_polarity_select,
					rx_nine_bit_select, tx_ninth_bit, tx_nine_bit_select, tx_enable,
					continuous_rx_enable, single_rx_enable, clock_source_master,
					sync_mode, port_enable};
				ssp_pkg::ADDR_STATUS: hrdata <= {27'h0000000, !tx_shift_full, rx_ninth_bit,
					overrun_error_flag, tx_buffer_empty_flag, rx_complete_flag};
				ssp_pkg::ADDR_RXDATA: hrdata <= {24'h000000, fifo_head[7:0]};
				ssp_pkg::ADDR_BAUD: hrdata <= {16'h0000, baud_divisor};
				ssp_pkg::ADDR_IRQ: hrdata <= {28'h0000000, global_irq_enable,
					peripheral_irq_enable, tx_irq_enable, rx_irq_enable};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_enable <= 1'b0;
			sync_mode <= 1'b0;
			clock_source_master <= 1'b0;
			single_rx_enable <= 1'b0;
			continuous_rx_enable <= 1'b0;
			tx_enable <= 1'b0;
			tx_nine_bit_select <= 1'b0;
			tx_ninth_bit <= 1'b0;
			rx_nine_bit_select <= 1'b0;
			clock_polarity_select <= 1'b0;
		end else begin
			if (rx_done && single_eff) begin
				single_rx_enable <= 1'b0;
			end
			if (dp_write && dp_addr == ssp_pkg::ADDR_CTRL) begin
				port_enable <= hwdata[ssp_pkg::CTRL_PORT_EN];
				sync_mode <= hwdata[ssp_pkg::CTRL_SYNC];
				clock_source_master <= hwdata[ssp_pkg::CTRL_MASTER];
				single_rx_enable <= hwdata[ssp_pkg::CTRL_SINGLE_RX];
				continuous_rx_enable <= hwdata[ssp_pkg::CTRL_CONT_RX];
				tx_enable <= hwdata[ssp_pkg::CTRL_TX_EN];
				tx_nine_bit_select <= hwdata[ssp_pkg::CTRL_TX_NINE];
				tx_ninth_bit <= hwdata[ssp_pkg::CTRL_TX_NINTH];
				rx_nine_bit_select <= hwdata[ssp_pkg::CTRL_RX_NINE];
				clock_polarity_select <= hwdata[ssp_pkg::CTRL_POLARITY];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			baud_divisor <= ssp_pkg::BAUD_RESET;
			rx_irq_enable <= 1'b0;
			tx_irq_enable <= 1'b0;
			peripheral_irq_enable <= 1'b0;
			global_irq_enable <= 1'b0;
		end else begin
			if (dp_write && dp_addr == ssp_pkg::ADDR_BAUD) begin
				baud_divisor <= hwdata[15:0];
			end
			if (dp_write && dp_addr == ssp_pkg::ADDR_IRQ) begin
				rx_irq_enable <= hwdata[ssp_pkg::IRQ_RX_EN];
				tx_irq_enable <= hwdata[ssp_pkg::IRQ_TX_EN];
				peripheral_irq_enable <= hwdata[ssp_pkg::IRQ_PERIPH_EN];
				global_irq_enable <= hwdata[ssp_pkg::IRQ_GLOBAL_EN];
			end
		end
	end

	// ************************************************************
	// Pin synchronisers and slave clock edge detection.
	// ************************************************************
	ssp_sync2 u_ck_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(ck_in),
		.sync_out(ck_sync)
	);

	ssp_sync2 u_dt_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(dt_in),
		.sync_out(dt_sync)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ck_prev <= 1'b0;
		end else begin
			ck_prev <= ck_sync;
		end
	end

	// Normalising by polarity makes the leading edge always a rise.
	assign ck_norm = ck_sync ^ clock_polarity_select;
	assign ck_prev_norm = ck_prev ^ clock_polarity_select;
	assign lead_ev = master_on ? mst_lead : (slave_on && ck_norm && !ck_prev_norm);
	assign trail_ev = master_on ? mst_trail : (slave_on && !ck_norm && ck_prev_norm);

	// ************************************************************
	// Master clock generator.
	// ************************************************************
	// The generator stops while an overrun stands, so no character is lost
	// on the wire that the queue could not hold. The last trailing edge of a
	// character also stops it, so a short divisor cannot start one clock too many.
	assign mck_run = master_on && ((rx_mode && !overrun_error_flag && !rx_ovr_set
		&& !(rx_done && single_eff && !continuous_rx_enable))
		|| (tx_mode && tx_shift_full && !(trail_ev && tx_left == 4'h1)));
	assign tick = half_cnt == baud_divisor;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mck_state <= CK_IDLE;
			half_cnt <= 16'h0000;
			mst_lead <= 1'b0;
			mst_trail <= 1'b0;
			ck_out <= 1'b0;
		end else begin
			mst_lead <= 1'b0;
			mst_trail <= 1'b0;
			half_cnt <= (tick || mck_state == CK_IDLE && !mck_run) ? 16'h0000 : half_cnt + 16'h0001;
			if (!mck_run) begin
				mck_state <= CK_IDLE;
				ck_out <= clock_polarity_select;
			end else if (tick) begin
				unique case (mck_state)
					CK_IDLE, CK_TRAIL_HALF: begin
						mck_state <= CK_LEAD_HALF;
						mst_lead <= 1'b1;
						ck_out <= !clock_polarity_select;
					end
					CK_LEAD_HALF: begin
						mck_state <= CK_TRAIL_HALF;
						mst_trail <= 1'b1;
						ck_out <= clock_polarity_select;
					end
					default: mck_state <= CK_IDLE;
				endcase
			end
		end
	end

	// ************************************************************
	// Transmit path.
	// ************************************************************
	assign tx_shift_load = tx_mode && hold_full && !tx_shift_full;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_holding_register <= 9'h000;
			hold_full <= 1'b0;
		end else if (port_rst) begin
			hold_full <= 1'b0;
		end else begin
			if (tx_shift_load) begin
				hold_full <= 1'b0;
			end
			if (dp_write && dp_addr == ssp_pkg::ADDR_TXDATA) begin
				tx_holding_register <= {tx_ninth_bit, hwdata[7:0]};
				hold_full <= 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_shift_register <= 9'h000;
			tx_shift_full <= 1'b0;
			tx_left <= 4'h0;
			dt_out <= 1'b0;
		end else if (port_rst) begin
			tx_shift_full <= 1'b0;
			tx_left <= 4'h0;
		end else if (tx_shift_load) begin
			tx_shift_register <= tx_holding_register;
			tx_shift_full <= 1'b1;
			tx_left <= tx_nine_bit_select ? ssp_pkg::BITS_WIDE : ssp_pkg::BITS_NARROW;
		end else if (tx_shift_full && tx_mode) begin
			if (lead_ev) begin
				dt_out <= tx_shift_register[0];
				tx_shift_register <= {1'b0, tx_shift_register[8:1]};
			end
			if (trail_ev) begin
				tx_left <= tx_left - 4'h1;
				if (tx_left == 4'h1) begin
					tx_shift_full <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dt_oe <= 1'b0;
			ck_oe <= 1'b0;
		end else begin
			dt_oe <= tx_mode;
			ck_oe <= master_on;
		end
	end

	// ************************************************************
	// Receive path.
	// ************************************************************
	assign rx_shift_next = {dt_sync, rx_shift_register[8:1]};
	assign rx_char = rx_nine_bit_select ? rx_shift_next : {1'b0, rx_shift_next[8:1]};
	assign rx_done = rx_mode && trail_ev && rx_cnt ==
		(rx_nine_bit_select ? ssp_pkg::LAST_BIT_WIDE : ssp_pkg::LAST_BIT_NARROW);
	assign rx_push = rx_done && !overrun_error_flag && !fifo_full;
	assign rx_ovr_set = rx_done && !overrun_error_flag && fifo_full;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_shift_register <= 9'h000;
			rx_cnt <= 4'h0;
		end else if (!rx_mode) begin
			rx_cnt <= 4'h0;
		end else if (trail_ev) begin
			rx_shift_register <= rx_shift_next;
			rx_cnt <= rx_done ? 4'h0 : rx_cnt + 4'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overrun_error_flag <= 1'b0;
			ovr_from_single <= 1'b0;
		end else if (port_rst) begin
			overrun_error_flag <= 1'b0;
		end else if (rx_ovr_set) begin
			overrun_error_flag <= 1'b1;
			ovr_from_single <= !continuous_rx_enable;
		end else if (overrun_error_flag) begin
			if (ovr_from_single ? rd_pop : !continuous_rx_enable) begin
				overrun_error_flag <= 1'b0;
			end
		end
	end

	ssp_rx_fifo #(
		.WIDTH(ssp_pkg::CHAR_WIDTH),
		.DEPTH(ssp_pkg::RX_FIFO_DEPTH)
	) u_rx_fifo (
		.hclk(hclk),
		.hresetn(hresetn),
		.flush(port_rst),
		.push(rx_push),
		.push_data(rx_char),
		.pop(rd_pop),
		.head_data(fifo_head),
		.empty(fifo_empty),
		.full(fifo_full)
	);

	// ************************************************************
	// Wake requests toward the core.
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_req <= 1'b0;
			vector_req <= 1'b0;
		end else begin
			wake_req <= peripheral_irq_enable && ((tx_buffer_empty_flag && tx_irq_enable)
				|| (rx_complete_flag && rx_irq_enable));
			vector_req <= global_irq_enable && peripheral_irq_enable
				&& ((tx_buffer_empty_flag && tx_irq_enable)
				|| (rx_complete_flag && rx_irq_enable));
		end
	end

	// ************************************************************
	// Assertions.
	// ************************************************************
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_MASTER_RX_RELEASES_DATA: assert property (rx_mode |=> !dt_oe)
		else $error("Data pin driven while receiving.");
	AST_SINGLE_CLEARS: assert property (rx_done && single_eff && !dp_write
		|=> !single_rx_enable)
		else $error("Single receive not cleared after a character.");
	AST_ABORT_STOPS_CLOCK: assert property (master_on && !tx_mode
		&& $fell(continuous_rx_enable) && !single_rx_enable
		|=> mck_state == CK_IDLE && ck_out == clock_polarity_select)
		else $error("Clock not stopped on continuous receive clear.");
	AST_PUSH_SETS_FLAG: assert property (rx_push |=> rx_complete_flag)
		else $error("Receive flag not set after a character.");
	AST_SLAVE_NO_CLOCK_DRIVE: assert property (slave_on |=> !ck_oe)
		else $error("Slave drives the clock pin.");
	AST_OVERRUN_SET: assert property (rx_done && fifo_full && !overrun_error_flag
		&& !rd_pop && port_on |=> overrun_error_flag)
		else $error("Overrun not flagged.");
	AST_OVERRUN_KEEPS_HEAD: assert property (overrun_error_flag && !rd_pop && port_on
		|=> $stable(fifo_head) && $stable(fifo_empty) && $stable(fifo_full))
		else $error("Queue changed during overrun.");
	AST_SHIFT_LOAD: assert property (tx_shift_load && !port_rst
		|=> tx_shift_full && (tx_buffer_empty_flag || $past(dp_write)))
		else $error("Holding register not moved to the shift register.");
	AST_WAKE_TX: assert property (peripheral_irq_enable && tx_irq_enable
		&& tx_buffer_empty_flag && $stable(peripheral_irq_enable) |=> wake_req)
		else $error("No wake on transmit flag.");
endmodule
`default_nettype wire

// ---- testbench/ssp_far_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssp_far_end (
	input wire logic ck_out, // Device clock drive value.
	input wire logic ck_oe, // Device clock driver enable.
	input wire logic dt_out, // Device data drive value.
	input wire logic dt_oe, // Device data driver enable.
	input wire logic [31:0] stream, // Bits to send, lowest first.
	input wire logic restart, // Rewinds the bit index.
	input wire logic go, // Starts a burst of clocks when we are master.
	input wire logic [3:0] burst, // Clock cycles in one burst.
	output logic ck_in, // Resolved clock pin level.
	output logic dt_in // Resolved data pin level.
);
	logic ck_m = 1'b0;
	logic bit_v = 1'b0;
	int idx = 0;
	assign ck_in = ck_oe ? ck_out : ck_m;
	assign dt_in = dt_oe ? dt_out : bit_v;
	// Each bit changes on the leading edge and holds to the next one.
	always @(posedge ck_in or posedge restart) begin
		if (restart) begin
			idx = 0;
		end else begin
			bit_v = stream[idx];
			idx = idx + 1;
		end
	end
	// The clock stands low between frames; only whole characters are clocked.
	initial forever begin
		@(posedge go);
		repeat (burst) begin
			#80 ck_m = 1'b1;
			#80 ck_m = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- testbench/ssp_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssp_top_test;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, dph = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, hrdata, rv, stream = 32'h0;
	logic hreadyout, hresp, ck_in, ck_out, ck_oe, dt_in, dt_out, dt_oe, wake_req, vector_req;
	logic restart = 1'b1, go = 1'b0;
	logic [15:0] cap = 16'h0000;
	logic [31:0] eq[$], mq[$];
	int err_total = 0, n_compared = 0, n_edge = 0, e0 = 0, seed = 32'h9F65;
	wire hready = hreadyout;
	ssp_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ck_in(ck_in), .ck_out(ck_out),
		.ck_oe(ck_oe), .dt_in(dt_in), .dt_out(dt_out), .dt_oe(dt_oe),
		.wake_req(wake_req), .vector_req(vector_req));
	ssp_far_end i_far (.ck_out(ck_out), .ck_oe(ck_oe), .dt_out(dt_out), .dt_oe(dt_oe),
		.stream(stream), .restart(restart), .go(go), .burst(4'h8), .ck_in(ck_in),
		.dt_in(dt_in));
	initial forever #4 hclk = ~hclk;
	always @(posedge ck_out) n_edge++;
	// The far end takes each driven bit at the trailing edge, lowest bit first.
	always @(negedge ck_in) if (dt_oe) cap <= {dt_in, cap[15:1]};
	task automatic stop_test();
		if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] e, m, g);
		n_compared++;
		if (((g ^ e) & m) !== 32'h0) begin
			err_total++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	// Read data is judged where it appears, against the oldest note.
	always @(posedge hclk) if (dph && hready) begin
		cmp(eq.pop_front(), mq.pop_front(), hrdata);
		cmp(32'h0, 32'h1, {31'h0, hresp});
	end
	task automatic wt();
		int i;
		i = 0;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			@(posedge hclk);
			i++;
			if (i > 50) begin
				err_total++;
				stop_test();
			end
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, e, m,
		output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wt();
		htrans <= 2'h0;
		hwdata <= d;
		dph <= !w;
		if (!w) begin
			eq.push_back(e);
			mq.push_back(m);
		end
		wt();
		r = hrdata;
		dph <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 32'h0, 32'h0, rv);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
		xfer(1'b0, a, 32'h0, e, m, rv);
	endtask
	// Polling reads carry an empty mask; only the bound on the loop can fail.
	task automatic poll(input int b);
		int i;
		rv = 32'h0;
		for (i = 0; i < 400 && rv[b] !== 1'b1; i++) rd(ssp_pkg::ADDR_STATUS, 32'h0, 32'h0);
		if (rv[b] !== 1'b1) begin
			err_total++;
			stop_test();
		end
	endtask
	task automatic rewind();
		restart <= 1'b1;
		@(posedge hclk);
		restart <= 1'b0;
		e0 = n_edge;
	endtask
	initial begin
		stream = $random(seed);
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(ssp_pkg::ADDR_BAUD, 32'h3, 32'hFFFFFFFF);
		rd(8'h40, 32'h0, 32'hFFFFFFFF);
		wr(ssp_pkg::ADDR_BAUD, 32'h1);
		wr(ssp_pkg::ADDR_IRQ, 32'h5);
		rewind();
		wr(ssp_pkg::ADDR_CTRL, 32'h0F);
		poll(ssp_pkg::STAT_RX_COMPLETE);
		cmp(32'h1, 32'h1, {31'h0, wake_req});
		cmp(32'h0, 32'h1, {31'h0, dt_oe});
		rd(ssp_pkg::ADDR_CTRL, 32'h0, 32'h8);
		rd(ssp_pkg::ADDR_RXDATA, {24'h0, stream[7:0]}, 32'hFFFFFFFF);
		rd(ssp_pkg::ADDR_STATUS, 32'h0, 32'h5);
		cmp(32'h8, 32'hFFFFFFFF, n_edge - e0);
		rewind();
		wr(ssp_pkg::ADDR_CTRL, 32'h117);
		poll(ssp_pkg::STAT_OVERRUN);
		rd(ssp_pkg::ADDR_STATUS, {28'h0, stream[8], 3'h5}, 32'hD);
		rd(ssp_pkg::ADDR_RXDATA, {24'h0, stream[7:0]}, 32'hFFFFFFFF);
		rd(ssp_pkg::ADDR_STATUS, {28'h0, stream[17], 3'h5}, 32'hD);
		rd(ssp_pkg::ADDR_RXDATA, {24'h0, stream[16:9]}, 32'hFFFFFFFF);
		cmp(32'h1B, 32'hFFFFFFFF, n_edge - e0);
		wr(ssp_pkg::ADDR_CTRL, 32'h107);
		// The overrun flag drops one cycle after the control write lands.
		@(posedge hclk);
		rd(ssp_pkg::ADDR_STATUS, 32'h0, 32'h5);
		stream <= $random(seed);
		wr(ssp_pkg::ADDR_IRQ, 32'hD);
		wr(ssp_pkg::ADDR_CTRL, 32'h13);
		rewind();
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
		cmp(32'h0, 32'h1, {31'h0, ck_oe});
		poll(ssp_pkg::STAT_RX_COMPLETE);
		cmp(32'h1, 32'h1, {31'h0, vector_req});
		rd(ssp_pkg::ADDR_RXDATA, {24'h0, stream[7:0]}, 32'hFFFFFFFF);
		rewind();
		wr(ssp_pkg::ADDR_CTRL, 32'h27);
		wr(ssp_pkg::ADDR_TXDATA, stream);
		wr(ssp_pkg::ADDR_TXDATA, {24'h0, stream[15:8]});
		rd(ssp_pkg::ADDR_STATUS, 32'h0, 32'h12);
		poll(ssp_pkg::STAT_TX_EMPTY);
		poll(ssp_pkg::STAT_SHIFT_EMPTY);
		cmp({16'h0, stream[15:0]}, 32'hFFFF, {16'h0, cap});
		cmp(32'h10, 32'hFFFFFFFF, n_edge - e0);
		stop_test();
	end
endmodule
`default_nettype wire
